// file: logic/accel_fmt_top.sv
// Output formatting, trim, resolution and auto-sleep control
`timescale 1ns/1ps
`include "accel_fmt_map.svh"
// Functional notes
// - Axis results are 12-bit, split high/low bytes
// - High byte holds upper eight result bits
// - Fast-read set serves only high bytes
// - 2 g range scales 1024 counts/g
// - 8 g range scales 256 counts/g
// - High-byte count weighs sixteen 12-bit counts
// - Trim loaded from storage at power-up
// - Six host-writable offset registers adjust zero-g
// - Low-noise bit reduces noise, limits to 4g
// - Mode field 10 selects high-resolution oversampling
// - Mode field 11 selects lowest-power scheme
// - Slowest rate gives highest resolution
// - Idle past timeout switches to sleep rate
// - Only detector events return to wake rate
// - 4 g range scales 512 counts/g
// - Standby keeps registers; activation clears data
module accel_fmt_top #(
	parameter int          ASLP_STEP_CYC = `ASLP_STEP_NS / `CLK_PERIOD_NS,
	parameter logic [95:0] TRIM_IMAGE    = `TRIM_IMAGE_DEF
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               link_clk,
	input  wire logic signed [15:0] raw_x,
	input  wire logic signed [15:0] raw_y,
	input  wire logic signed [15:0] raw_z,
	input  wire logic               raw_valid,
	input  wire logic [3:0]         wake_evt,
	input  wire logic [7:0]         lk_addr,
	input  wire logic [7:0]         lk_wdata,
	input  wire logic               lk_wr,
	input  wire logic               lk_rd,
	output logic [7:0]              lk_rdata,
	output logic                    lk_rvalid,
	output logic                    lk_busy,
	output logic [2:0]              odr_sel,
	output logic                    sleeping,
	output logic                    trim_done
);
	localparam int PW = $clog2(ASLP_STEP_CYC + 1);

	// Link side request holding and reset synchroniser
	logic       lrst_s1_ff, lrst_s2_ff;
	logic       req_tog_ff, wr_hold_ff, rd_hold_ff, busy_ff;
	logic [7:0] addr_hold_ff, wdata_hold_ff, lk_rdata_ff;
	logic       ack_s1_ff, ack_s2_ff, ack_s3_ff, rvalid_ff;
	logic       lk_take, ack_seen;

	// Core side
	logic       req_s1_ff, req_s2_ff, req_s3_ff, ack_tog_ff;
	logic       req_new, wr_now, rd_now;
	logic [7:0] rdata_core_ff, rd_word;
	logic [7:0] ctrl1_ff, ctrl2_ff, aslp_ff;
	logic [1:0] fs_ff;
	logic [7:0] ofs_ff [6];
	logic [7:0] sens_ff [3];
	logic signed [15:0] toff_ff [3];
	logic signed [15:0] raw_arr [3];
	accel_fmt_pkg::sample_t out_ff [3];
	accel_fmt_pkg::mode_t   mode_ff, nxt_mode;
	logic       drdy_ff, nxt_drdy;
	logic [2:0] ld_idx_ff, nxt_odr, odr_ff;
	logic [1:0] cnt_ff, n_m1, eff_oversampling_mode_field, fsh;
	logic [2:0] tot_sh;
	logic [PW-1:0] presc_ff;
	logic [8:0] step_ff;
	logic       act, fread, low_noise_bit, slpe, hires, lowpwr, lim_ln;
	logic       smp_en, commit, go_active, sleep_due, any_evt;
	logic       ofs_hit;
	logic [7:0] ofs_rel;

	trim_if tif ();

	trim_store #(
		.IMAGE (TRIM_IMAGE)
	) u_trim (
		.clk  (clk),
		.port (tif)
	);

	// Two-way handshake: one request in flight, held until ack
	assign lk_take  = (lk_wr | lk_rd) & ~busy_ff;
	assign ack_seen = ack_s2_ff ^ ack_s3_ff;
	assign lk_busy  = busy_ff;
	assign lk_rdata = lk_rdata_ff;
	assign lk_rvalid = rvalid_ff;

	// Reset reaches the link domain through two flops
	always_ff @(posedge link_clk) begin
		lrst_s1_ff <= rst;
		lrst_s2_ff <= lrst_s1_ff;
	end

	// Capture a request; write wins when both strobes come together
	always_ff @(posedge link_clk) begin
		if (lrst_s2_ff) begin
			req_tog_ff    <= 1'b0;
			busy_ff       <= 1'b0;
			wr_hold_ff    <= 1'b0;
			rd_hold_ff    <= 1'b0;
			addr_hold_ff  <= 8'h00;
			wdata_hold_ff <= 8'h00;
		end else if (lk_take) begin
			req_tog_ff    <= ~req_tog_ff;
			busy_ff       <= 1'b1;
			wr_hold_ff    <= lk_wr;
			rd_hold_ff    <= ~lk_wr;
			addr_hold_ff  <= lk_addr;
			wdata_hold_ff <= lk_wdata;
		end else if (ack_seen) begin
			busy_ff <= 1'b0;
		end
	end

	// Ack returns by toggle; read data is loaded as it flips and stable while it crosses
	always_ff @(posedge link_clk) begin
		if (lrst_s2_ff) begin
			ack_s1_ff   <= 1'b0;
			ack_s2_ff   <= 1'b0;
			ack_s3_ff   <= 1'b0;
			rvalid_ff   <= 1'b0;
			lk_rdata_ff <= 8'h00;
		end else begin
			ack_s1_ff <= ack_tog_ff;
			ack_s2_ff <= ack_s1_ff;
			ack_s3_ff <= ack_s2_ff;
			rvalid_ff <= ack_seen & rd_hold_ff;
			if (ack_seen & rd_hold_ff) begin
				lk_rdata_ff <= rdata_core_ff;
			end
		end
	end

	// Request toggle into the core domain
	always_ff @(posedge clk) begin
		if (rst) begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			req_s3_ff <= 1'b0;
		end else begin
			req_s1_ff <= req_tog_ff;
			req_s2_ff <= req_s1_ff;
			req_s3_ff <= req_s2_ff;
		end
	end

	// Held address and data are static while the toggle crosses
	assign req_new = req_s2_ff ^ req_s3_ff;
	assign wr_now  = req_new & wr_hold_ff;
	assign rd_now  = req_new & rd_hold_ff;
	assign ofs_rel = addr_hold_ff - `A_OFS_BASE;
	assign ofs_hit = ofs_rel < `OFS_COUNT;

	// Control decode
	assign act    = ctrl1_ff[`C1_ACTIVE];
	assign fread  = ctrl1_ff[`C1_FREAD];
	assign low_noise_bit = ctrl1_ff[`C1_LOW_NOISE_BIT];
	assign slpe   = ctrl2_ff[`C2_SLPE];
	assign sleeping = mode_ff == accel_fmt_pkg::M_SLEEP;
	assign trim_done = mode_ff != accel_fmt_pkg::M_LOAD;
	assign odr_sel  = odr_ff;

	// Sleep uses its own rate and oversampling field
	assign nxt_odr = (nxt_mode == accel_fmt_pkg::M_SLEEP)
		? {1'b1, ctrl1_ff[`C1_SDR_LO +: 2]}
		: ctrl1_ff[`C1_WDR_LO +: 3];
	assign eff_oversampling_mode_field = sleeping ? ctrl2_ff[`C2_SMODS_LO +: 2]
		: ctrl2_ff[`C2_WMODS_LO +: 2];
	assign hires  = (eff_oversampling_mode_field == `OVERSAMPLING_MODE_FIELD_HIRES)
		| (odr_ff == `DR_SLOWEST);
	assign lowpwr = eff_oversampling_mode_field == `OVERSAMPLING_MODE_FIELD_LOWPWR;
	// Averaging depth: four for high resolution, two for low noise
	assign n_m1   = hires ? 2'd3 : (low_noise_bit ? 2'd1 : 2'd0);
	assign fsh    = (fs_ff == `FS_RSVD) ? `FS_8G : fs_ff;
	assign tot_sh = 3'(n_m1 == 2'd3 ? 2 : n_m1) + 3'd2
		+ 3'(fsh);
	assign lim_ln = low_noise_bit & (fsh == `FS_8G);

	// Sample sequencing
	assign smp_en = raw_valid & (mode_ff[2] | mode_ff[3]);
	assign commit = smp_en & (cnt_ff == n_m1);
	assign go_active = (mode_ff == accel_fmt_pkg::M_STBY) & act;
	assign any_evt = |wake_evt;
	assign sleep_due = slpe & ~any_evt
		& (step_ff > {1'b0, aslp_ff});

	// Trim fetch port
	assign tif.addr = ld_idx_ff;
	assign tif.rd   = (mode_ff == accel_fmt_pkg::M_LOAD)
		& (ld_idx_ff < 3'd6);

	assign raw_arr[0] = raw_x;
	assign raw_arr[1] = raw_y;
	assign raw_arr[2] = raw_z;

	// Mode sequencing
	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			accel_fmt_pkg::M_LOAD: begin
				if (ld_idx_ff == 3'd6) nxt_mode = accel_fmt_pkg::M_STBY;
			end
			accel_fmt_pkg::M_STBY: begin
				if (act) nxt_mode = accel_fmt_pkg::M_WAKE;
			end
			accel_fmt_pkg::M_WAKE: begin
				if (!act) nxt_mode = accel_fmt_pkg::M_STBY;
				else if (sleep_due) nxt_mode = accel_fmt_pkg::M_SLEEP;
			end
			accel_fmt_pkg::M_SLEEP: begin
				if (!act) nxt_mode = accel_fmt_pkg::M_STBY;
				else if (any_evt) nxt_mode = accel_fmt_pkg::M_WAKE;
			end
			default: nxt_mode = accel_fmt_pkg::M_LOAD;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_ff   <= accel_fmt_pkg::M_LOAD;
			ld_idx_ff <= 3'd0;
			odr_ff    <= 3'd0;
		end else begin
			mode_ff <= nxt_mode;
			odr_ff  <= nxt_odr;
			if (mode_ff == accel_fmt_pkg::M_LOAD && ld_idx_ff != 3'd6)
				ld_idx_ff <= ld_idx_ff + 3'd1;
		end
	end

	// Idle timer counts whole steps without a detector event
	always_ff @(posedge clk) begin
		if (rst || mode_ff != accel_fmt_pkg::M_WAKE || any_evt) begin
			presc_ff <= '0;
			step_ff  <= 9'd0;
		end else if (presc_ff == PW'(ASLP_STEP_CYC - 1)) begin
			presc_ff <= '0;
			if (step_ff != 9'h1ff) step_ff <= step_ff + 9'd1;
		end else begin
			presc_ff <= presc_ff + PW'(1);
		end
	end

	// Host-writable control; contents survive standby
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl1_ff <= `CTRL1_RST;
			ctrl2_ff <= `CTRL2_RST;
			fs_ff    <= `FS_RST;
			aslp_ff  <= `ASLP_RST;
		end else if (wr_now) begin
			if (addr_hold_ff == `A_CTRL1) ctrl1_ff <= wdata_hold_ff;
			if (addr_hold_ff == `A_CTRL2) ctrl2_ff <= wdata_hold_ff;
			if (addr_hold_ff == `A_FSCALE) fs_ff <= wdata_hold_ff[1:0];
			if (addr_hold_ff == `A_ASLP) aslp_ff <= wdata_hold_ff;
		end
	end

	// Six volatile user offset bytes, high byte first per axis
	for (genvar i = 0; i < 6; i++) begin : g_ofs
		always_ff @(posedge clk) begin
			if (rst) begin
				ofs_ff[i] <= 8'h00;
			end else if (wr_now && ofs_hit && ofs_rel == 8'(i)) begin
				ofs_ff[i] <= wdata_hold_ff;
			end
		end
	end

	// Data ready: a new result wins over a status read
	assign nxt_drdy = commit | (drdy_ff & ~(rd_now
		&& addr_hold_ff == `A_STATUS));

	always_ff @(posedge clk) begin
		if (rst || go_active) begin
			drdy_ff <= 1'b0;
			cnt_ff  <= 2'd0;
		end else begin
			drdy_ff <= nxt_drdy;
			if (smp_en) cnt_ff <= commit ? 2'd0 : cnt_ff + 2'd1;
		end
	end

	// Per-axis trim, offset, averaging, scaling and saturation
	for (genvar a = 0; a < 3; a++) begin : g_axis
		logic signed [24:0] prod;
		logic signed [18:0] corr;
		logic signed [20:0] acc_ff, acc_sum, scl, hi, lo;
		logic [11:0] sat, fin;

		// Gain trim is unsigned with unity at 128
		assign prod = raw_arr[a] * $signed({1'b0, sens_ff[a]});
		assign corr = 19'($signed(prod[24:7])) + 19'(toff_ff[a])
			+ 19'($signed({ofs_ff[2*a], ofs_ff[2*a+1]}));
		assign acc_sum = acc_ff + 21'(corr);
		assign scl = acc_sum >>> tot_sh;
		assign hi  = lim_ln ? 21'sd1023 : 21'sd2047;
		assign lo  = lim_ln ? -21'sd1024 : -21'sd2048;
		assign sat = (scl > hi) ? hi[11:0]
			: (scl < lo) ? lo[11:0] : scl[11:0];
		// Low-power scheme drops the two finest bits
		assign fin = lowpwr ? {sat[11:2], 2'b00} : sat;

		always_ff @(posedge clk) begin
			if (rst) begin
				sens_ff[a] <= 8'h00;
				toff_ff[a] <= 16'sh0000;
			end else if (mode_ff == accel_fmt_pkg::M_LOAD) begin
				if (ld_idx_ff == 3'(a + 1)) sens_ff[a] <= tif.data[7:0];
				if (ld_idx_ff == 3'(a + 4)) toff_ff[a] <= tif.data;
			end
		end

		always_ff @(posedge clk) begin
			if (rst || go_active) begin
				acc_ff    <= 21'sd0;
				out_ff[a] <= 12'h000;
			end else if (smp_en) begin
				acc_ff <= commit ? 21'sd0 : acc_sum;
				if (commit) out_ff[a] <= fin;
			end
		end
	end

	function automatic logic [7:0] hi_byte(
		input accel_fmt_pkg::sample_t s);
		return s[11:4];
	endfunction : hi_byte

	// Low byte is left justified; zero while fast-read is set
	function automatic logic [7:0] lo_byte(
		input accel_fmt_pkg::sample_t s, input logic f);
		return f ? 8'h00 : {s[3:0], 4'h0};
	endfunction : lo_byte

	// Register read decode
	always_comb begin
		rd_word = 8'h00;
		case (addr_hold_ff)
			`A_STATUS:  rd_word = {4'h0, drdy_ff, 3'h0};
			`A_XH:      rd_word = hi_byte(out_ff[0]);
			`A_XL:      rd_word = lo_byte(out_ff[0], fread);
			`A_YH:      rd_word = hi_byte(out_ff[1]);
			`A_YL:      rd_word = lo_byte(out_ff[1], fread);
			`A_ZH:      rd_word = hi_byte(out_ff[2]);
			`A_ZL:      rd_word = lo_byte(out_ff[2], fread);
			`A_SYSMODE: rd_word = {6'h0, mode_ff[3], mode_ff[2]};
			`A_FSCALE:  rd_word = {6'h0, fs_ff};
			`A_ASLP:    rd_word = aslp_ff;
			`A_CTRL1:   rd_word = ctrl1_ff;
			`A_CTRL2:   rd_word = ctrl2_ff;
			default: begin
				if (ofs_hit) rd_word = ofs_ff[ofs_rel[2:0]];
			end
		endcase
	end

	// Every request, read or write, answers by toggling the ack
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_tog_ff    <= 1'b0;
			rdata_core_ff <= 8'h00;
		end else if (req_new) begin
			ack_tog_ff    <= ~ack_tog_ff;
			rdata_core_ff <= rd_word;
		end
	end

	sequence s_go_sleep;
		mode_ff == accel_fmt_pkg::M_WAKE ##1
		mode_ff == accel_fmt_pkg::M_SLEEP;
	endsequence

	sequence s_activate;
		mode_ff == accel_fmt_pkg::M_STBY && act ##1
		mode_ff == accel_fmt_pkg::M_WAKE;
	endsequence

	a_fread_low: assert property (@(posedge clk) disable iff (rst)
		rd_now && fread && addr_hold_ff == `A_XL |=> rdata_core_ff == 8'h00)
		else $error("low byte not zero in fast-read");

	a_high_byte: assert property (@(posedge clk) disable iff (rst)
		rd_now && addr_hold_ff == `A_XH
		|=> rdata_core_ff == $past(out_ff[0][11:4]))
		else $error("high byte does not match result");

	a_trim_load: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> ##[6:8] trim_done && sens_ff[0] == TRIM_IMAGE[7:0]
		&& toff_ff[2] == $signed(TRIM_IMAGE[95:80]))
		else $error("trim not loaded after reset");

	a_ln_range: assert property (@(posedge clk) disable iff (rst)
		commit && lim_ln |=> $signed(out_ff[0]) <= 12'sd1023
		&& $signed(out_ff[0]) >= -12'sd1024)
		else $error("low-noise range exceeded");

	a_lowpwr_lsb: assert property (@(posedge clk) disable iff (rst)
		commit && lowpwr |=> out_ff[1][1:0] == 2'b00)
		else $error("low-power result kept fine bits");

	// A result must not move before the fourth averaged sample lands
	a_hires_avg: assert property (@(posedge clk) disable iff (rst)
		smp_en && hires && cnt_ff != 2'd3 |=> $stable(out_ff[0]))
		else $error("high-res result before four samples");

	a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
		s_go_sleep |-> $past(slpe) && $past(step_ff) > {1'b0, aslp_ff})
		else $error("sleep entered without timeout");

	a_wake_event: assert property (@(posedge clk) disable iff (rst)
		sleeping && act && any_evt |=> mode_ff == accel_fmt_pkg::M_WAKE)
		else $error("event did not wake");

	a_act_clear: assert property (@(posedge clk) disable iff (rst)
		s_activate |-> out_ff[2] == 12'h000 && !drdy_ff)
		else $error("data not cleared on activation");

	a_link_ack: assert property (@(posedge link_clk)
		disable iff (lrst_s2_ff)
		$rose(busy_ff) |-> ##[2:40] !busy_ff)
		else $error("link request never answered");

endmodule : accel_fmt_top

// file: logic/trim_store.sv
// Non-volatile trim image with registered read data
`timescale 1ns/1ps
`include "accel_fmt_map.svh"
module trim_store #(
	parameter logic [95:0] IMAGE = `TRIM_IMAGE_DEF
) (
	input wire logic clk,
	trim_if.mem      port
);

	// Words 0..2 are gain trims, 3..5 offset trims
	always_ff @(posedge clk) begin
		if (port.rd) begin
			port.data <= IMAGE[16 * port.addr +: 16];
		end
	end

endmodule : trim_store

// file: pkg/accel_fmt_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ACCEL_FMT_MAP_SVH
`define ACCEL_FMT_MAP_SVH

// Register offsets
`define A_STATUS     8'h00
`define A_XH         8'h01
`define A_XL         8'h02
`define A_YH         8'h03
`define A_YL         8'h04
`define A_ZH         8'h05
`define A_ZL         8'h06
`define A_SYSMODE    8'h0b
`define A_FSCALE     8'h0e
`define A_ASLP       8'h29
`define A_CTRL1      8'h2a
`define A_CTRL2      8'h2b
`define A_OFS_BASE   8'h2f
`define OFS_COUNT    8'h06

// control_one fields
`define C1_ACTIVE    0
`define C1_FREAD     1
`define C1_LOW_NOISE_BIT    2
`define C1_WDR_LO    3
`define C1_SDR_LO    6
// control_two fields
`define C2_WMODS_LO  0
`define C2_SLPE      2
`define C2_SMODS_LO  3

// Field encodings
`define OVERSAMPLING_MODE_FIELD_HIRES   2'h2
`define OVERSAMPLING_MODE_FIELD_LOWPWR  2'h3
`define DR_SLOWEST   3'h7
`define FS_8G        2'h2
`define FS_RSVD      2'h3

// Reset values
`define CTRL1_RST    8'h00
`define CTRL2_RST    8'h00
`define FS_RST       2'h0
`define ASLP_RST     8'h00

// Sensitivity trim word that means unity gain
`define SENS_UNITY   16'h0080
`define TRIM_IMAGE_DEF {48'h0, {3{`SENS_UNITY}}}

// Timing
`define CLK_PERIOD_NS 50
`define ASLP_STEP_NS  320000000

`endif

// file: pkg/accel_fmt_pkg.sv
// Types shared by the output formatting block
package accel_fmt_pkg;

	// Operating mode, one-hot
	typedef enum logic [3:0] {
		M_LOAD  = 4'b0001,
		M_STBY  = 4'b0010,
		M_WAKE  = 4'b0100,
		M_SLEEP = 4'b1000
	} mode_t;

	typedef logic signed [11:0] sample_t;

endpackage : accel_fmt_pkg

// file: pkg/trim_if.sv
// Read port between the formatter and its trim store
`timescale 1ns/1ps
interface trim_if;
	logic [2:0]  addr;
	logic        rd;
	logic [15:0] data;
	modport master (output addr, output rd, input data);
	modport mem    (input addr, input rd, output data);
endinterface : trim_if

// file: test/accel_output_format_power_modes_tb_top.sv
// Bench for the formatter: host traffic, samples, ranges and auto-sleep
`timescale 1ns/1ps
`include "accel_fmt_map.svh"
module accel_output_format_power_modes_tb_top;
	// Trim image: unity gains, X offset +64, Y 0, Z -16 raw units
	localparam logic [95:0] TRIM = {16'hfff0, 16'h0000, 16'h0040,
		{3{16'h0080}}};
	// Cases {full scale, low noise, mode field, fast read}
	localparam logic [5:0] CASES [6] = '{6'b00_0_00_0, 6'b01_0_01_0,
		6'b10_0_10_0, 6'b10_1_11_1, 6'b00_1_00_0, 6'b11_0_01_1};
	logic               clk = 1'b0;
	logic               link_clk = 1'b0;
	logic               rst = 1'b1;
	logic               raw_valid = 1'b0;
	logic signed [15:0] raw_x = 16'sh0000;
	logic signed [15:0] raw_y = 16'sh0000;
	logic signed [15:0] raw_z = 16'sh0000;
	logic [3:0]         wake_evt = 4'h0;
	wire [7:0]          lk_addr;
	wire [7:0]          lk_wdata;
	wire [7:0]          lk_rdata;
	wire                lk_wr;
	wire                lk_rd;
	wire                lk_rvalid;
	wire                lk_busy;
	wire [2:0]          odr_sel;
	wire                sleeping;
	wire                trim_done;
	int                 err_count = 0;
	int                 n_compared = 0;
	integer             seed = 32'h8594680c;
	logic signed [15:0] uofs [3];
	logic signed [15:0] rv [3];
	logic               ok;

	always #25 clk = ~clk;
	// Link edges alternate between half nanoseconds and core clock edges
	always #62.5 link_clk = ~link_clk;

	accel_fmt_top #(.ASLP_STEP_CYC(8), .TRIM_IMAGE(TRIM)) dut (.clk,
		.rst, .link_clk, .raw_x, .raw_y, .raw_z, .raw_valid, .wake_evt,
		.lk_addr, .lk_wdata, .lk_wr, .lk_rd, .lk_rdata, .lk_rvalid,
		.lk_busy, .odr_sel, .sleeping, .trim_done);
	link_host host (.link_clk, .lk_addr, .lk_wdata, .lk_wr, .lk_rd,
		.lk_rdata, .lk_rvalid, .lk_busy);

	// Expected 12-bit result from one repeated sample
	function automatic logic [11:0] expect_out(input logic signed [15:0] r,
		input logic signed [15:0] t, input logic signed [15:0] u,
		input logic [1:0] fs, input logic ln, input logic lp);
		logic signed [17:0] s;
		logic signed [17:0] lim;
		s = r + t + u;
		s = s >>> (fs[1] ? 4 : 2 + fs);
		lim = (ln && fs[1]) ? 18'sd1023 : 18'sd2047;
		if (s > lim)
			s = lim;
		else if (s < -lim - 18'sd1)
			s = -lim - 18'sd1;
		if (lp)
			s[1:0] = 2'b00;
		return s[11:0];
	endfunction : expect_out

	task automatic print_verdict();
		$display("Counts: %0d compared, %0d mismatches", n_compared,
			err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [11:0] seen, input logic [11:0] exp,
		input string what);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t %s: seen %h expected %h", $time, what,
				seen, exp);
		end
	endtask : check

	// A link transfer that never answers ends the run
	task automatic link(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] v);
		host.xfer(w, a, d, v, ok);
		if (ok !== 1'b1) begin
			err_count++;
			$display("MISMATCH t=%0t link answer timed out", $time);
			print_verdict();
		end
	endtask : link

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		logic [7:0] v;
		link(1'b0, a, 8'h00, v);
		check({4'h0, v}, {4'h0, exp}, what);
	endtask : rdchk

	task automatic wait_sleep(input logic lvl, input int lim);
		int n;
		for (n = 0; n < lim && sleeping !== lvl; n++)
			@(negedge clk);
		check({11'h0, sleeping}, {11'h0, lvl}, "sleep state");
		if (sleeping !== lvl)
			print_verdict();
	endtask : wait_sleep

	// Same sample repeated so any averaging depth gives the same value
	task automatic send(input int n);
		repeat (n) begin
			@(posedge clk);
			raw_valid <= 1'b1;
			raw_x <= rv[0];
			raw_y <= rv[1];
			raw_z <= rv[2];
			@(posedge clk);
			raw_valid <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : send

	initial begin
		int         i;
		int         k;
		logic [1:0] fs;
		logic [1:0] md;
		logic [1:0] prev_md;
		logic       ln;
		logic       fr;
		logic [2:0] rate;
		logic [11:0] e;
		logic [7:0] v;
		prev_md = 2'b00;
		// Held longer than two cycles so the link domain sees it too
		repeat (10) @(posedge clk);
		@(negedge clk);
		check({lk_busy, lk_rvalid, sleeping, trim_done, odr_sel}, 12'h0,
			"outputs in reset");
		@(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 20 && trim_done !== 1'b1; i++)
			@(negedge clk);
		check({11'h0, trim_done}, 12'h1, "trim fetch");
		repeat (4) @(posedge link_clk);
		for (k = 0; k < 3; k++) begin
			uofs[k] = 16'($random(seed)) >>> 3;
			link(1'b1, `A_OFS_BASE + 8'(2 * k), uofs[k][15:8], v);
			link(1'b1, `A_OFS_BASE + 8'(2 * k + 1), uofs[k][7:0], v);
		end
		rdchk(`A_OFS_BASE + 8'h2, uofs[1][15:8], "offset readback");
		rdchk(8'h7f, 8'h00, "unmapped read");
		for (i = 0; i < 12; i++) begin
			{fs, ln, md, fr} = CASES[i % 6];
			rate = 3'($random(seed));
			link(1'b1, `A_CTRL1, 8'h00, v);
			rdchk(`A_CTRL2, {6'h0, prev_md}, "kept in standby");
			link(1'b1, `A_FSCALE, {6'h0, fs}, v);
			link(1'b1, `A_CTRL2, {6'h0, md}, v);
			prev_md = md;
			link(1'b1, `A_CTRL1, {2'b00, rate, ln, fr, 1'b1}, v);
			rdchk(`A_XH, 8'h00, "cleared on activation");
			rdchk(`A_SYSMODE, 8'h01, "wake mode");
			@(negedge clk);
			check({9'h0, odr_sel}, {9'h0, rate}, "wake rate");
			for (k = 0; k < 3; k++)
				rv[k] = 16'($random(seed));
			if (i == 0)
				rv = '{16'sh7fff, 16'sh8000, 16'sh0ffc};
			send(4);
			for (k = 0; k < 3; k++) begin
				e = expect_out(rv[k], TRIM[48 + 16 * k +: 16], uofs[k], fs,
					ln, md == 2'b11);
				rdchk(`A_XH + 8'(2 * k), e[11:4], "high byte");
				rdchk(`A_XL + 8'(2 * k), fr ? 8'h00 : {e[3:0], 4'h0},
					"low byte");
			end
			$display("Range case %0d done", i);
		end
		// Auto-sleep: timeout of 4 steps, sleep rate 01, wake rate 011
		link(1'b1, `A_CTRL1, 8'h00, v);
		link(1'b1, `A_ASLP, 8'h04, v);
		link(1'b1, `A_CTRL2, 8'h04, v);
		link(1'b1, `A_CTRL1, 8'h59, v);
		@(negedge clk);
		check({11'h0, sleeping}, 12'h0, "awake before timeout");
		wait_sleep(1'b1, 400);
		repeat (4) @(negedge clk);
		check({9'h0, odr_sel}, 12'h005, "sleep rate");
		repeat (60) @(negedge clk);
		check({11'h0, sleeping}, 12'h1, "stays asleep");
		for (k = 0; k < 4; k++) begin
			@(posedge clk);
			wake_evt <= 4'h1 << k;
			@(posedge clk);
			wake_evt <= 4'h0;
			wait_sleep(1'b0, 4);
			repeat (4) @(negedge clk);
			check({9'h0, odr_sel}, 12'h003, "wake rate back");
			wait_sleep(1'b1, 400);
		end
		$display("Auto-sleep test done");
		print_verdict();
	end
endmodule : accel_output_format_power_modes_tb_top

// file: test/link_host.sv
// Host-side model of the register link: one request in flight at a time
`timescale 1ns/1ps
module link_host (
	input  wire logic       link_clk,
	output logic [7:0]      lk_addr,
	output logic [7:0]      lk_wdata,
	output logic            lk_wr,
	output logic            lk_rd,
	input  wire logic [7:0] lk_rdata,
	input  wire logic       lk_rvalid,
	input  wire logic       lk_busy
);
	// Idle values until the first request
	initial begin
		lk_addr = 8'h00;
		lk_wdata = 8'h00;
		lk_wr = 1'b0;
		lk_rd = 1'b0;
	end

	// Strobe for one edge, then wait for busy to rise and fall again.
	// Address and data are inverted once released, so a design that
	// samples them late sees garbage rather than a lucky stale value.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		int   n;
		logic seen;
		seen = 1'b0;
		ok = 1'b0;
		q = 8'h00;
		@(posedge link_clk);
		lk_wr <= w;
		lk_rd <= !w;
		lk_addr <= a;
		lk_wdata <= d;
		@(posedge link_clk);
		lk_wr <= 1'b0;
		lk_rd <= 1'b0;
		lk_addr <= ~a;
		lk_wdata <= ~d;
		for (n = 0; n < 40; n++) begin
			@(posedge link_clk);
			#1;
			if (seen && lk_busy === 1'b0) begin
				ok = w || lk_rvalid === 1'b1;
				q = lk_rdata;
				n = 40;
			end
			seen = seen | (lk_busy === 1'b1);
		end
	endtask : xfer
endmodule : link_host
